// ==== src/pesc_pkg.sv ====
package pesc_pkg;

  // attribute services
  localparam logic [7:0]  SVC_GET         = 8'h0E;
  localparam logic [7:0]  SVC_SET         = 8'h10;

  // object instances
  localparam logic [15:0] INST_ACT        = 16'h2D34;
  localparam logic [15:0] INST_ENC        = 16'h2D35;
  localparam logic [15:0] INST_CYC        = 16'h2D36;
  localparam logic [15:0] INST_TURN       = 16'h2D37;
  localparam logic [15:0] INST_RES        = 16'h2D38;

  // attribute ids
  localparam logic [7:0]  ATTR_0          = 8'h00;
  localparam logic [7:0]  ATTR_1          = 8'h01;
  localparam logic [7:0]  ATTR_2          = 8'h02;

  // activation object
  localparam logic [15:0] ACT_KEY         = 16'h1EA5;
  localparam logic [31:0] ACT_RD_BUSY     = 32'h0000_0000;
  localparam logic [31:0] ACT_RD_IDLE     = 32'h0000_0001;
  localparam int          ACT_CNT_W       = 5;
  localparam logic [4:0]  ACT_CYCLES      = 5'h10;
  localparam logic [4:0]  ACT_CNT_ZERO    = 5'h00;
  localparam logic [4:0]  ACT_CNT_ONE     = 5'h01;

  // encoder status object
  localparam logic [31:0] ENC_ENTRIES     = 32'h0000_0002;
  localparam int          ENC_ABS_BIT     = 0;
  localparam int          ENC_SCALE_EN_BIT = 1;
  localparam int          ENC_SCALE_ABS_BIT = 2;

  // answer status codes
  localparam logic [7:0]  ST_OK           = 8'h00;
  localparam logic [7:0]  ST_SVC_UNSUP    = 8'h08;
  localparam logic [7:0]  ST_BAD_VALUE    = 8'h09;
  localparam logic [7:0]  ST_STATE_CONFLICT = 8'h0C;
  localparam logic [7:0]  ST_NOT_SETTABLE = 8'h0E;
  localparam logic [7:0]  ST_ATTR_UNSUP   = 8'h14;
  localparam logic [7:0]  ST_NO_OBJECT    = 8'h16;

  localparam logic [31:0] WORD_ZERO       = 32'h0000_0000;

  typedef enum logic [1:0] {
    SK_ROTARY  = 2'b00,
    SK_LIN_ABS = 2'b01,
    SK_LIN_INC = 2'b10,
    SK_LIN_ABZ = 2'b11
  } pesc_scale_kind_t;

  typedef enum logic {
    ACT_IDLE = 1'b0,
    ACT_RUN  = 1'b1
  } pesc_act_state_t;

endpackage

// ==== src/pesc_act_if.sv ====
`timescale 1ns/1ns
interface pesc_act_if;
  logic        start;
  logic        busy;
  logic        staged_we;
  logic [31:0] staged_data;
  logic [31:0] active;

  modport ctrl (output start, output staged_we, output staged_data, input busy, input active);
  modport eng  (input start, input staged_we, input staged_data, output busy, output active);
endinterface

// ==== src/pesc_activator.sv ====
`timescale 1ns/1ns
module pesc_activator (
  // clock and reset
  input  wire logic  clk_i,
  input  wire logic  rstn_i,
  // activation channel
  pesc_act_if.eng    act
);
  import pesc_pkg::*;

  pesc_act_state_t        state_q, state_d;
  logic [ACT_CNT_W-1:0]   cnt_q, cnt_d;
  logic [31:0]            staged_q, staged_d;
  logic [31:0]            active_q, active_d;

  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    staged_d = act.staged_we ? act.staged_data : staged_q;
    active_d = active_q;
    case (state_q)
      ACT_IDLE: begin
        if (act.start) begin
          state_d = ACT_RUN;
          cnt_d   = ACT_CYCLES - ACT_CNT_ONE;
        end
      end
      ACT_RUN: begin
        if (cnt_q == ACT_CNT_ZERO) begin
          state_d  = ACT_IDLE;
          active_d = staged_q;
        end else begin
          cnt_d = cnt_q - ACT_CNT_ONE;
        end
      end
      default: state_d = ACT_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q  <= ACT_IDLE;
      cnt_q    <= ACT_CNT_ZERO;
      staged_q <= WORD_ZERO;
      active_q <= WORD_ZERO;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      staged_q <= staged_d;
      active_q <= active_d;
    end
  end

  assign act.busy   = (state_q == ACT_RUN);
  assign act.active = active_q;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  deferred_hold_a: assert property (!$stable(active_q) |-> $past(state_q) == ACT_RUN)
    else $error("deferred value changed without activation");
  // two runs of eight make up the sixteen busy cycles of one pass
  act_length_a: assert property (
      $rose(act.busy) |-> act.busy[*8] ##1 act.busy[*8] ##1 !act.busy)
    else $error("activation length wrong");
  cover_act_done_c: cover property ($fell(act.busy));
endmodule

// ==== src/pesc_obj_bank.sv ====
`timescale 1ns/1ns
// Operation
// - deferred parameters wait for explicit activation
// - writing 1EA5h starts activating pending parameters
// - activation read 0 busy, 1 done
// - fully closed loop reports external encoder status
// - bit 0 absolute versus incremental system
// - first status bits 1-31 reserved zero
// - second status bit 1 scale enabled
// - second status bit 2 scale absolute type
// - second status bits 3-31 reserved zero
// - cycle count selected by scale type
// - turn count multi-turn rotary, zero linear
// - resolution returned unsigned increments per revolution
// - readable objects served by get 0Eh
// - writable objects served by set 10h
module pesc_obj_bank (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rstn_i,
  // attribute request
  input  wire logic                       req_valid_i,
  input  wire logic [7:0]                 req_service_i,
  input  wire logic [15:0]                req_instance_i,
  input  wire logic [7:0]                 req_attr_i,
  input  wire logic [31:0]                req_wdata_i,
  input  wire logic                       io_run_i,
  // attribute answer
  output logic                            rsp_valid_o,
  output logic [7:0]                      rsp_status_o,
  output logic [31:0]                     rsp_data_o,
  // deferred parameter
  input  wire logic                       staged_we_i,
  input  wire logic [31:0]                staged_data_i,
  output logic [31:0]                     active_param_o,
  // encoder state
  input  wire logic                       abs_system_i,
  input  wire logic                       full_closed_i,
  input  wire logic                       ext_abs_i,
  input  wire logic                       scale_en_i,
  input  wire logic                       scale_abs_i,
  input  wire pesc_pkg::pesc_scale_kind_t scale_kind_i,
  input  wire logic [31:0]                scale_cycle_i,
  input  wire logic [31:0]                scale_abs_cnt_i,
  input  wire logic [31:0]                scale_coast_i,
  input  wire logic signed [31:0]         multi_turn_counter_i,
  input  wire logic [31:0]                scale_res_i
);
  import pesc_pkg::*;

  pesc_act_if act ();

  pesc_activator u_act (
    .clk_i  (clk_i),
    .rstn_i (rstn_i),
    .act    (act)
  );

  logic        rsp_valid_q, rsp_valid_d;
  logic [7:0]  rsp_status_q, rsp_status_d;
  logic [31:0] rsp_data_q, rsp_data_d;
  logic        start_q, start_d;
  logic        obj_ok;
  logic        attr_ok;
  logic        writable;
  logic [31:0] rd_val;
  logic [31:0] status1;
  logic [31:0] status2;
  logic [31:0] cyc_val;
  logic [31:0] turn_val;

  assign act.start       = start_q;
  assign act.staged_we   = staged_we_i;
  assign act.staged_data = staged_data_i;

  always_comb begin
    status1 = WORD_ZERO;
    // the loop encoder that closes position feeds bit 0
    status1[ENC_ABS_BIT] = full_closed_i ? ext_abs_i : abs_system_i;
    status2 = WORD_ZERO;
    status2[ENC_ABS_BIT]       = abs_system_i;
    status2[ENC_SCALE_EN_BIT]  = scale_en_i;
    status2[ENC_SCALE_ABS_BIT] = scale_abs_i;
    case (scale_kind_i)
      SK_ROTARY:  cyc_val = scale_cycle_i;
      SK_LIN_ABS: cyc_val = scale_abs_cnt_i;
      default:    cyc_val = scale_coast_i;
    endcase
    turn_val = (scale_kind_i == SK_ROTARY) ? multi_turn_counter_i : WORD_ZERO;
  end

  always_comb begin
    obj_ok   = 1'b1;
    attr_ok  = (req_attr_i == ATTR_0);
    writable = 1'b0;
    rd_val   = WORD_ZERO;
    case (req_instance_i)
      INST_ACT: begin
        writable = 1'b1;
        // a start still in flight already counts as busy
        rd_val = (act.busy || start_q) ? ACT_RD_BUSY : ACT_RD_IDLE;
      end
      INST_ENC: begin
        attr_ok = (req_attr_i == ATTR_0) || (req_attr_i == ATTR_1) || (req_attr_i == ATTR_2);
        case (req_attr_i)
          ATTR_0:  rd_val = ENC_ENTRIES;
          ATTR_1:  rd_val = status1;
          ATTR_2:  rd_val = status2;
          default: rd_val = WORD_ZERO;
        endcase
      end
      INST_CYC:  rd_val = cyc_val;
      INST_TURN: rd_val = turn_val;
      INST_RES:  rd_val = scale_res_i;
      default:   obj_ok = 1'b0;
    endcase
  end

  always_comb begin
    rsp_valid_d  = req_valid_i;
    rsp_status_d = rsp_status_q;
    rsp_data_d   = rsp_data_q;
    start_d      = 1'b0;
    if (req_valid_i) begin
      rsp_status_d = ST_OK;
      rsp_data_d   = WORD_ZERO;
      if (!obj_ok) begin
        rsp_status_d = ST_NO_OBJECT;
      end else if (!attr_ok) begin
        rsp_status_d = ST_ATTR_UNSUP;
      end else if (req_service_i == SVC_GET) begin
        rsp_data_d = rd_val;
      end else if (req_service_i == SVC_SET) begin
        if (!writable) begin
          rsp_status_d = ST_NOT_SETTABLE;
        end else if (io_run_i) begin
          rsp_status_d = ST_STATE_CONFLICT;
        end else if (req_wdata_i[15:0] != ACT_KEY) begin
          rsp_status_d = ST_BAD_VALUE;
        end else begin
          // a repeat key while busy is accepted but folds into the running pass
          start_d = !act.busy;
        end
      end else begin
        rsp_status_d = ST_SVC_UNSUP;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rsp_valid_q  <= 1'b0;
      rsp_status_q <= ST_OK;
      rsp_data_q   <= WORD_ZERO;
      start_q      <= 1'b0;
    end else begin
      rsp_valid_q  <= rsp_valid_d;
      rsp_status_q <= rsp_status_d;
      rsp_data_q   <= rsp_data_d;
      start_q      <= start_d;
    end
  end

  assign rsp_valid_o    = rsp_valid_q;
  assign rsp_status_o   = rsp_status_q;
  assign rsp_data_o     = rsp_data_q;
  assign active_param_o = act.active;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence set_act_s;
    req_valid_i && req_service_i == SVC_SET && req_instance_i == INST_ACT && req_attr_i == ATTR_0;
  endsequence
  sequence get_s;
    req_valid_i && req_service_i == SVC_GET;
  endsequence

  key_starts_a: assert property (
      set_act_s and (!io_run_i && req_wdata_i[15:0] == ACT_KEY && !act.busy)
      |=> start_q ##1 act.busy)
    else $error("activation key did not start");
  run_refused_a: assert property (
      set_act_s and io_run_i |=> !start_q && rsp_status_q == ST_STATE_CONFLICT)
    else $error("activation taken while running");
  busy_read_a: assert property (
      get_s and (req_instance_i == INST_ACT && act.busy) |=> rsp_data_q == ACT_RD_BUSY)
    else $error("busy activation read nonzero");
  idle_read_a: assert property (
      get_s and (req_instance_i == INST_ACT && !act.busy && !start_q && req_attr_i == ATTR_0)
      |=> rsp_data_q == ACT_RD_IDLE)
    else $error("idle activation read not one");
  status1_src_a: assert property (
      get_s and (req_instance_i == INST_ENC && req_attr_i == ATTR_1)
      |=> rsp_data_q == {31'h0000_0000,
      ($past(full_closed_i) ? $past(ext_abs_i) : $past(abs_system_i))})
    else $error("status1 wrong");
  status2_bits_a: assert property (
      get_s and (req_instance_i == INST_ENC && req_attr_i == ATTR_2)
      |=> rsp_data_q == {29'h0000_0000, $past(scale_abs_i), $past(scale_en_i),
      $past(abs_system_i)})
    else $error("status2 wrong");
  entry_count_a: assert property (
      get_s and (req_instance_i == INST_ENC && req_attr_i == ATTR_0)
      |=> rsp_data_q == ENC_ENTRIES && rsp_status_q == ST_OK)
    else $error("entry count wrong");
  linear_turn_a: assert property (
      get_s and (req_instance_i == INST_TURN && req_attr_i == ATTR_0 && scale_kind_i != SK_ROTARY)
      |=> rsp_data_q == WORD_ZERO)
    else $error("linear turn count nonzero");
  rotary_turn_a: assert property (
      get_s and (req_instance_i == INST_TURN && req_attr_i == ATTR_0 && scale_kind_i == SK_ROTARY)
      |=> rsp_data_q == $past(multi_turn_counter_i))
    else $error("rotary turn count wrong");
  linear_cycle_a: assert property (
      get_s and (req_instance_i == INST_CYC && req_attr_i == ATTR_0 && scale_kind_i == SK_LIN_ABS)
      |=> rsp_data_q == $past(scale_abs_cnt_i))
    else $error("linear cycle count wrong");
  resolution_read_a: assert property (
      get_s and (req_instance_i == INST_RES && req_attr_i == ATTR_0)
      |=> rsp_data_q == $past(scale_res_i))
    else $error("resolution wrong");
  answer_timing_a: assert property (
      req_valid_i |=> rsp_valid_q ##1 (!rsp_valid_q || $past(req_valid_i)))
    else $error("answer not one cycle after request");

  cover_key_c:       cover property (set_act_s and (!io_run_i && req_wdata_i[15:0] == ACT_KEY));
  cover_conflict_c:  cover property (set_act_s and io_run_i);
  cover_status2_c:   cover property (get_s and (req_instance_i == INST_ENC && req_attr_i == ATTR_2));
  cover_busy_read_c: cover property (get_s and (req_instance_i == INST_ACT && act.busy));
endmodule

// ==== bench/pesc_ctrl_model.sv ====
`timescale 1ns/1ns
module pesc_ctrl_model (
  // clock and answer
  input  wire logic        clk_i,
  input  wire logic        rsp_valid_i,
  input  wire logic [7:0]  rsp_status_i,
  input  wire logic [31:0] rsp_data_i,
  // request
  output logic             req_valid_o,
  output logic [7:0]       req_service_o,
  output logic [15:0]      req_instance_o,
  output logic [7:0]       req_attr_o,
  output logic [31:0]      req_wdata_o
);
  initial begin
    req_valid_o = 1'b0;
    {req_service_o, req_instance_o, req_attr_o, req_wdata_o} = '1;
  end

  // fields are inverted once released so a stale request never looks valid
  task automatic xfer(input logic [7:0] svc, input logic [15:0] inst,
                      input logic [7:0] attr, input logic [31:0] wd,
                      output logic [7:0] st, output logic [31:0] rd, output int lat);
    @(negedge clk_i);
    req_valid_o = 1'b1;
    {req_service_o, req_instance_o, req_attr_o, req_wdata_o} = {svc, inst, attr, wd};
    lat = 0;
    @(negedge clk_i);
    req_valid_o = 1'b0;
    {req_service_o, req_instance_o, req_attr_o, req_wdata_o} = ~{svc, inst, attr, wd};
    while (rsp_valid_i !== 1'b1 && lat < 4) begin
      @(negedge clk_i);
      lat++;
    end
    st = rsp_status_i;
    rd = rsp_data_i;
  endtask
endmodule

// ==== bench/param_enable_scale_encoder_objects_bench.sv ====
`timescale 1ns/1ns
module param_enable_scale_encoder_objects_bench;
  import pesc_pkg::*;
  logic clk = 1'b0, rstn = 1'b0, io_run = 1'b0, sw = 1'b0;
  logic abs_sys = 1'b0, full_cl = 1'b0, ext_abs = 1'b0, sc_en = 1'b0, sc_abs = 1'b0;
  logic [31:0] sd = 32'hA5A5_0F0F, cyc = 32'h1234_5678, acnt = 32'h0ABC_DEF0;
  logic [31:0] coast = 32'h00FF_00FF, res = 32'h8000_0001;
  logic signed [31:0] mt = 32'hFFFF_FFFB;
  pesc_scale_kind_t kind = SK_ROTARY;
  logic v, rv;
  logic [7:0] sv, at, rs;
  logic [15:0] ins;
  logic [31:0] wd, rd, act;
  int fails = 0, cmp_count = 0, cyc_cnt = 0;

  pesc_ctrl_model i_ctrl (.clk_i(clk), .rsp_valid_i(rv), .rsp_status_i(rs), .rsp_data_i(rd),
    .req_valid_o(v), .req_service_o(sv), .req_instance_o(ins), .req_attr_o(at),
    .req_wdata_o(wd));

  pesc_obj_bank i_dut (.clk_i(clk), .rstn_i(rstn), .req_valid_i(v), .req_service_i(sv),
    .req_instance_i(ins), .req_attr_i(at), .req_wdata_i(wd), .io_run_i(io_run),
    .rsp_valid_o(rv), .rsp_status_o(rs), .rsp_data_o(rd), .staged_we_i(sw),
    .staged_data_i(sd), .active_param_o(act), .abs_system_i(abs_sys),
    .full_closed_i(full_cl), .ext_abs_i(ext_abs), .scale_en_i(sc_en), .scale_abs_i(sc_abs),
    .scale_kind_i(kind), .scale_cycle_i(cyc), .scale_abs_cnt_i(acnt),
    .scale_coast_i(coast), .multi_turn_counter_i(mt), .scale_res_i(res));

  initial begin
    forever #5 clk = ~clk;
  end

  task automatic give_verdict();
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic req(input logic [7:0] s, input logic [15:0] i, input logic [7:0] a,
                     input logic [31:0] w, input logic [7:0] est, input logic [31:0] ed);
    logic [7:0] st;
    logic [31:0] d;
    int lat;
    i_ctrl.xfer(s, i, a, w, st, d, lat);
    chk("latency", 32'h0, 32'(lat));
    chk("status", {24'h0, est}, {24'h0, st});
    chk("data", ed, d);
  endtask

  task automatic t_enc();
    req(SVC_GET, INST_ENC, ATTR_0, 0, ST_OK, ENC_ENTRIES);
    abs_sys = 1'b1;
    req(SVC_GET, INST_ENC, ATTR_1, 0, ST_OK, 32'h1);
    full_cl = 1'b1;
    req(SVC_GET, INST_ENC, ATTR_1, 0, ST_OK, 32'h0);
    abs_sys = 1'b0;
    ext_abs = 1'b1;
    req(SVC_GET, INST_ENC, ATTR_1, 0, ST_OK, 32'h1);
    for (int i = 0; i < 8; i++) begin
      {sc_abs, sc_en, abs_sys} = 3'(i);
      req(SVC_GET, INST_ENC, ATTR_2, 0, ST_OK, 32'(i));
    end
  endtask

  task automatic t_scale();
    for (int k = 0; k < 4; k++) begin
      kind = pesc_scale_kind_t'(k);
      req(SVC_GET, INST_CYC, ATTR_0, 0, ST_OK, k == 0 ? cyc : k == 1 ? acnt : coast);
      req(SVC_GET, INST_TURN, ATTR_0, 0, ST_OK, k == 0 ? 32'hFFFF_FFFB : WORD_ZERO);
    end
    req(SVC_GET, INST_RES, ATTR_0, 0, ST_OK, 32'h8000_0001);
  endtask

  task automatic t_act();
    sw = 1'b1;
    @(negedge clk);
    sw = 1'b0;
    req(SVC_GET, INST_ACT, ATTR_0, 0, ST_OK, ACT_RD_IDLE);
    io_run = 1'b1;
    req(SVC_SET, INST_ACT, ATTR_0, {16'h0, ACT_KEY}, ST_STATE_CONFLICT, WORD_ZERO);
    io_run = 1'b0;
    req(SVC_SET, INST_ACT, ATTR_0, 32'h1EA4, ST_BAD_VALUE, WORD_ZERO);
    repeat (20) @(negedge clk);
    chk("active", WORD_ZERO, act);
    req(SVC_SET, INST_ACT, ATTR_0, {16'hFFFF, ACT_KEY}, ST_OK, WORD_ZERO);
    req(SVC_GET, INST_ACT, ATTR_0, 0, ST_OK, ACT_RD_BUSY);
    chk("active", WORD_ZERO, act);
    repeat (20) @(negedge clk);
    req(SVC_GET, INST_ACT, ATTR_0, 0, ST_OK, ACT_RD_IDLE);
    chk("active", 32'hA5A5_0F0F, act);
  endtask

  task automatic t_err();
    req(SVC_SET, INST_RES, ATTR_0, 1, ST_NOT_SETTABLE, WORD_ZERO);
    req(8'h4C, INST_CYC, ATTR_0, 0, ST_SVC_UNSUP, WORD_ZERO);
    req(SVC_GET, 16'h2D39, ATTR_0, 0, ST_NO_OBJECT, WORD_ZERO);
    req(SVC_GET, INST_ENC, 8'h03, 0, ST_ATTR_UNSUP, WORD_ZERO);
  endtask

  // the whole run is about 110 cycles; this only cuts a hang
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt == 3000) begin
      fails++;
      give_verdict();
    end
  end

  initial begin
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk("active", WORD_ZERO, act);
    t_enc();
    t_scale();
    t_act();
    t_err();
    give_verdict();
  end
endmodule
